// ==== hdl/osd_detector.sv ====
// original size detector: sensor decode, by-pass gating, register slave
`timescale 1ns/1ps
module osd_detector (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // avalon-mm slave
   input wire logic [osd_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [osd_pkg::DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [osd_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // sensor pins; on the four size pins a low level means paper present, the registration pin is high with paper
   input wire logic width_sense_first_in,
   input wire logic width_sense_second_in,
   input wire logic length_sense_first_in,
   input wire logic length_sense_second_in,
   input wire logic platen_cover_in,
   input wire logic reg_sensor_in,
   // machine controller strobes, same clock
   input wire logic start_key_in,
   input wire logic page_start_in,
   input wire logic line_tick_in,
   input wire logic video_in,
   // results
   output osd_pkg::osd_size_t size_out,
   output logic [osd_pkg::CODE_W-1:0] display_code_out,
   output logic undetectable_out,
   output logic size_valid_out,
   output logic full_area_scan_out,
   output logic video_out,
   output logic irq_out
);

   // ==========================================================
   // pin synchronisation
   osd_sync_if sif();
   logic [osd_pkg::SYNC_W-1:0] pins;

   // every pin is sampled all the time; nothing is gated here
   always_comb begin
      pins = '0;
      pins[osd_pkg::SY_W1] = width_sense_first_in;
      pins[osd_pkg::SY_W2] = width_sense_second_in;
      pins[osd_pkg::SY_L1] = length_sense_first_in;
      pins[osd_pkg::SY_L2] = length_sense_second_in;
      pins[osd_pkg::SY_COVER] = platen_cover_in;
      pins[osd_pkg::SY_REG] = reg_sensor_in;
   end

   assign sif.raw = pins;

   osd_sync u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .port(sif.syncer)
   );

   // ==========================================================
   // control register state, written over the bus below
   logic [osd_pkg::CTRL_W-1:0] ctrl_r;
   logic [osd_pkg::CTRL_W-1:0] ctrl_nxt;
   logic [osd_pkg::IRQ_W-1:0] stat_r;
   logic [osd_pkg::IRQ_W-1:0] stat_nxt;
   logic [osd_pkg::IRQ_W-1:0] mask_r;
   logic [osd_pkg::IRQ_W-1:0] mask_nxt;
   logic bypass_en;
   logic undet_nondefault;

   assign bypass_en = ctrl_r[osd_pkg::CTRL_BYPASS];
   assign undet_nondefault = ctrl_r[osd_pkg::CTRL_UNDET_SET];

   // ==========================================================
   // sensor pattern and evaluation instant
   logic [osd_pkg::PAT_W-1:0] live_pat;
   logic cover_now;
   logic cover_d_r;
   logic cover_d_nxt;
   logic eval;

   // a high pin is no paper, so the pattern bit is the inverse
   always_comb begin
      live_pat = ~{sif.sync[osd_pkg::SY_L2], sif.sync[osd_pkg::SY_L1],
                   sif.sync[osd_pkg::SY_W2], sif.sync[osd_pkg::SY_W1]};
      cover_now = sif.sync[osd_pkg::SY_COVER];
      cover_d_nxt = cover_now;
      // cover edge while closing, or start with the platen open
      eval = (cover_now & ~cover_d_r)
           | (start_key_in & ~cover_now);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cover_d_r <= 1'b0;
      end else begin
         cover_d_r <= cover_d_nxt;
      end
   end

   // ==========================================================
   // pattern decode; a pure table, so no scan of the page is needed
   osd_pkg::osd_size_t dec_size;
   logic dec_ok;

   always_comb begin
      dec_ok = 1'b1;
      case (live_pat)
         osd_pkg::PAT_XL: dec_size = osd_pkg::SZ_XL;
         osd_pkg::PAT_LG: dec_size = osd_pkg::SZ_LG;
         osd_pkg::PAT_LONG: dec_size = osd_pkg::SZ_LONG;
         osd_pkg::PAT_SEF: dec_size = osd_pkg::SZ_SEF;
         osd_pkg::PAT_LEF_WIDE: dec_size = osd_pkg::SZ_LEF_WIDE;
         osd_pkg::PAT_LEF_MID: dec_size = osd_pkg::SZ_LEF_MID;
         osd_pkg::PAT_LEF_SMALL: dec_size = osd_pkg::SZ_LEF_SMALL;
         osd_pkg::PAT_ALT: dec_size = osd_pkg::SZ_ALT;
         default: begin
            dec_size = osd_pkg::SZ_NONE;
            dec_ok = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // latched result, only an evaluation moves it
   osd_pkg::osd_size_t size_r;
   osd_pkg::osd_size_t size_nxt;
   logic [osd_pkg::CODE_W-1:0] code_r;
   logic [osd_pkg::CODE_W-1:0] code_nxt;
   logic undet_r;
   logic undet_nxt;
   logic valid_r;
   logic valid_nxt;
   logic full_r;
   logic full_nxt;
   logic ev_eval;
   logic ev_undet;

   always_comb begin
      size_nxt = size_r;
      code_nxt = code_r;
      undet_nxt = undet_r;
      valid_nxt = valid_r;
      full_nxt = full_r;
      ev_eval = 1'b0;
      ev_undet = 1'b0;
      if (eval) begin
         ev_eval = 1'b1;
         if (bypass_en) begin
            // sensors ignored: scan the whole largest area
            size_nxt = osd_pkg::SZ_XL;
            code_nxt = {osd_pkg::PAT_XL, osd_pkg::CODE_LOW};
            undet_nxt = 1'b0;
            valid_nxt = 1'b1;
            full_nxt = 1'b1;
         end else begin
            size_nxt = dec_size;
            code_nxt = {live_pat, osd_pkg::CODE_LOW};
            valid_nxt = dec_ok;
            // a non-default setting silences the warning
            undet_nxt = ~dec_ok & ~undet_nondefault;
            ev_undet = ~dec_ok & ~undet_nondefault;
            full_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         size_r <= osd_pkg::SZ_NONE;
         code_r <= '0;
         undet_r <= 1'b0;
         valid_r <= 1'b0;
         full_r <= 1'b0;
      end else begin
         size_r <= size_nxt;
         code_r <= code_nxt;
         undet_r <= undet_nxt;
         valid_r <= valid_nxt;
         full_r <= full_nxt;
      end
   end

   // ==========================================================
   // paper length at the registration sensor, then video cut
   logic reg_now;
   logic reg_d_r;
   logic reg_d_nxt;
   logic [osd_pkg::LEN_W-1:0] meas_r;
   logic [osd_pkg::LEN_W-1:0] meas_nxt;
   logic [osd_pkg::LEN_W-1:0] plen_r;
   logic [osd_pkg::LEN_W-1:0] plen_nxt;
   logic plen_ok_r;
   logic plen_ok_nxt;
   logic [osd_pkg::LEN_W-1:0] line_r;
   logic [osd_pkg::LEN_W-1:0] line_nxt;
   logic cut_r;
   logic cut_nxt;
   logic video_r;
   logic video_nxt;
   logic ev_cut;

   // counters saturate, so a stuck sensor cannot wrap the length
   always_comb begin
      reg_now = sif.sync[osd_pkg::SY_REG];
      reg_d_nxt = reg_now;
      meas_nxt = meas_r;
      plen_nxt = plen_r;
      plen_ok_nxt = plen_ok_r;
      line_nxt = line_r;
      cut_nxt = cut_r;
      ev_cut = 1'b0;
      if (reg_now & ~reg_d_r) begin
         meas_nxt = '0;
      end else if (reg_now & line_tick_in & (meas_r != osd_pkg::LEN_MAX)) begin
         meas_nxt = meas_r + osd_pkg::LEN_ONE;
      end
      if (~reg_now & reg_d_r) begin
         plen_nxt = meas_r;
         plen_ok_nxt = 1'b1;
      end
      if (page_start_in) begin
         line_nxt = '0;
         cut_nxt = 1'b0;
      end else begin
         if (line_tick_in & (line_r != osd_pkg::LEN_MAX)) begin
            line_nxt = line_r + osd_pkg::LEN_ONE;
         end
         if (bypass_en & plen_ok_r & ~cut_r & (line_r >= plen_r)) begin
            cut_nxt = 1'b1;
            ev_cut = 1'b1;
         end
      end
      video_nxt = video_in & ~(cut_r & bypass_en);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         reg_d_r <= 1'b0;
         meas_r <= '0;
         plen_r <= '0;
         plen_ok_r <= 1'b0;
         line_r <= '0;
         cut_r <= 1'b0;
         video_r <= 1'b0;
      end else begin
         reg_d_r <= reg_d_nxt;
         meas_r <= meas_nxt;
         plen_r <= plen_nxt;
         plen_ok_r <= plen_ok_nxt;
         line_r <= line_nxt;
         cut_r <= cut_nxt;
         video_r <= video_nxt;
      end
   end

   // ==========================================================
   // avalon slave: one wait state, then the answer
   osd_pkg::osd_bus_t bus_r;
   osd_pkg::osd_bus_t bus_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [osd_pkg::DATA_W-1:0] rdata_r;
   logic [osd_pkg::DATA_W-1:0] rdata_nxt;
   logic [osd_pkg::DATA_W-1:0] rd_mux;
   logic irq_r;
   logic irq_nxt;
   logic wr_go;
   logic lo_lane;
   logic [osd_pkg::IRQ_W-1:0] events;
   logic [osd_pkg::IRQ_W-1:0] w1c;

   // read data, unmapped addresses read as zero
   always_comb begin
      rd_mux = '0;
      case (avs_address_in)
         osd_pkg::OFS_CTRL:
            rd_mux[osd_pkg::CTRL_W-1:0] = ctrl_r;
         osd_pkg::OFS_RESULT: begin
            rd_mux[osd_pkg::RES_CODE_LSB +: osd_pkg::CODE_W] = code_r;
            rd_mux[osd_pkg::RES_SIZE_LSB +: 4] = size_r;
            rd_mux[osd_pkg::RES_UNDET] = undet_r;
            rd_mux[osd_pkg::RES_VALID] = valid_r;
            rd_mux[osd_pkg::RES_FULL] = full_r;
            rd_mux[osd_pkg::RES_LIVE_LSB +: osd_pkg::PAT_W] = live_pat;
         end
         osd_pkg::OFS_IRQ_STAT:
            rd_mux[osd_pkg::IRQ_W-1:0] = stat_r;
         osd_pkg::OFS_IRQ_MASK:
            rd_mux[osd_pkg::IRQ_W-1:0] = mask_r;
         osd_pkg::OFS_PAPER_LEN:
            rd_mux[osd_pkg::LEN_W-1:0] = plen_r;
         default: rd_mux = '0;
      endcase
   end

   // bus phase, register writes and sticky status
   always_comb begin
      bus_nxt = bus_r;
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      w1c = '0;
      wr_go = 1'b0;
      lo_lane = avs_byteenable_in[0];
      case (bus_r)
         osd_pkg::BUS_IDLE: begin
            if (avs_read_in | avs_write_in) begin
               bus_nxt = osd_pkg::BUS_ACK;
               wait_nxt = 1'b0;
               rdata_nxt = avs_read_in ? rd_mux : '0;
            end
         end
         osd_pkg::BUS_ACK: begin
            // the master sees waitrequest low here: commit now
            bus_nxt = osd_pkg::BUS_IDLE;
            wr_go = avs_write_in & lo_lane;
         end
         default: bus_nxt = osd_pkg::BUS_IDLE;
      endcase
      if (wr_go) begin
         case (avs_address_in)
            osd_pkg::OFS_CTRL:
               ctrl_nxt = avs_writedata_in[osd_pkg::CTRL_W-1:0];
            osd_pkg::OFS_IRQ_MASK:
               mask_nxt = avs_writedata_in[osd_pkg::IRQ_W-1:0];
            osd_pkg::OFS_IRQ_STAT:
               w1c = avs_writedata_in[osd_pkg::IRQ_W-1:0];
            default: w1c = '0;
         endcase
      end
      events = '0;
      events[osd_pkg::IRQ_EVAL] = ev_eval;
      events[osd_pkg::IRQ_UNDET] = ev_undet;
      events[osd_pkg::IRQ_CUT] = ev_cut;
      // a new event beats a clear in the same cycle
      stat_nxt = (stat_r & ~w1c) | events;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         bus_r <= osd_pkg::BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= '0;
         ctrl_r <= osd_pkg::CTRL_RST;
         mask_r <= osd_pkg::IRQ_RST;
         stat_r <= osd_pkg::IRQ_RST;
         irq_r <= 1'b0;
      end else begin
         bus_r <= bus_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign size_out = size_r;
   assign display_code_out = code_r;
   assign undetectable_out = undet_r;
   assign size_valid_out = valid_r;
   assign full_area_scan_out = full_r;
   assign video_out = video_r;
   assign irq_out = irq_r;

endmodule

// ==== hdl/osd_pkg.sv ====
// constants and types shared by the original size detector files
package osd_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_PAPER_LEN = 5'h10;

   // ==========================================================
   // control register fields
   localparam int CTRL_W = 2;
   localparam int CTRL_BYPASS = 0;
   localparam int CTRL_UNDET_SET = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

   // ==========================================================
   // result register fields
   localparam int RES_CODE_LSB = 0;
   localparam int RES_SIZE_LSB = 8;
   localparam int RES_UNDET = 12;
   localparam int RES_VALID = 13;
   localparam int RES_FULL = 14;
   localparam int RES_LIVE_LSB = 16;

   // ==========================================================
   // interrupt status and mask fields
   localparam int IRQ_W = 3;
   localparam int IRQ_EVAL = 0;
   localparam int IRQ_UNDET = 1;
   localparam int IRQ_CUT = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // ==========================================================
   // sensor pattern and display code
   localparam int PAT_W = 4;
   localparam int CODE_W = 8;
   localparam logic [PAT_W-1:0] CODE_LOW = 4'h0;
   localparam logic [PAT_W-1:0] PAT_XL = 4'hf;
   localparam logic [PAT_W-1:0] PAT_LG = 4'hd;
   localparam logic [PAT_W-1:0] PAT_LONG = 4'hc;
   localparam logic [PAT_W-1:0] PAT_SEF = 4'h4;
   localparam logic [PAT_W-1:0] PAT_LEF_WIDE = 4'h3;
   localparam logic [PAT_W-1:0] PAT_LEF_MID = 4'h1;
   localparam logic [PAT_W-1:0] PAT_LEF_SMALL = 4'h0;
   localparam logic [PAT_W-1:0] PAT_ALT = 4'h5;

   // ==========================================================
   // synchronised pin vector layout
   localparam int SYNC_W = 6;
   localparam int SY_W1 = 0;
   localparam int SY_W2 = 1;
   localparam int SY_L1 = 2;
   localparam int SY_L2 = 3;
   localparam int SY_COVER = 4;
   localparam int SY_REG = 5;

   // ==========================================================
   // paper length counters
   localparam int LEN_W = 16;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
   localparam logic [LEN_W-1:0] LEN_MAX = 16'hffff;

   // ==========================================================
   // decoded original sizes
   typedef enum logic [3:0] {
      SZ_NONE,
      SZ_XL,
      SZ_LG,
      SZ_LONG,
      SZ_SEF,
      SZ_LEF_WIDE,
      SZ_LEF_MID,
      SZ_LEF_SMALL,
      SZ_ALT
   } osd_size_t;

   // bus slave phases
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } osd_bus_t;

endpackage

// ==== hdl/osd_sync.sv ====
// two-flop synchroniser for all asynchronous sensor pins
`timescale 1ns/1ps
module osd_sync (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // pins in, safe levels out
   osd_sync_if.syncer port
);

   logic [osd_pkg::SYNC_W-1:0] meta_r;
   logic [osd_pkg::SYNC_W-1:0] meta_nxt;
   logic [osd_pkg::SYNC_W-1:0] safe_r;
   logic [osd_pkg::SYNC_W-1:0] safe_nxt;

   // ==========================================================
   // one chain per pin; the first stage feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < osd_pkg::SYNC_W; gi++) begin : g_bit
         always_comb begin
            meta_nxt[gi] = port.raw[gi];
            safe_nxt[gi] = meta_r[gi];
         end

         always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
               meta_r[gi] <= 1'b0;
               safe_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= meta_nxt[gi];
               safe_r[gi] <= safe_nxt[gi];
            end
         end
      end
   endgenerate

   assign port.sync = safe_r;

endmodule

// ==== hdl/osd_sync_if.sv ====
// carrier between the detector core and its pin synchroniser
`timescale 1ns/1ps
interface osd_sync_if;
   logic [osd_pkg::SYNC_W-1:0] raw;
   logic [osd_pkg::SYNC_W-1:0] sync;

   // core hands over raw pins and reads the synchronised copy
   modport core (output raw, input sync);
   // synchroniser reads raw pins and drives the safe copy
   modport syncer (input raw, output sync);
endinterface

// ==== verification/osd_detector_properties.sv ====
// port checker for the original size detector
`timescale 1ns/1ps
module osd_detector_properties (
   // clock, reset and bus handshake
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   // sensor pins and strobes
   input wire logic width_sense_first_in,
   input wire logic width_sense_second_in,
   input wire logic length_sense_first_in,
   input wire logic length_sense_second_in,
   input wire logic platen_cover_in,
   input wire logic start_key_in,
   input wire logic video_in,
   // results
   input wire osd_pkg::osd_size_t size_out,
   input wire logic [7:0] display_code_out,
   input wire logic undetectable_out,
   input wire logic size_valid_out,
   input wire logic full_area_scan_out,
   input wire logic video_out
);
   // =====
   // helpers: pin pattern as bits, result bundle
   logic [3:0] pin_pat;
   logic [14:0] res;
   assign pin_pat = ~{length_sense_second_in, length_sense_first_in,
      width_sense_second_in, width_sense_first_in};
   assign res = {size_out, display_code_out, undetectable_out,
      size_valid_out, full_area_scan_out};

   // accepted pattern to size encoding, zero when not accepted
   function automatic logic [3:0] size_of(input logic [3:0] p);
      case (p)
         4'hf: size_of = 4'h1;
         4'hd: size_of = 4'h2;
         4'hc: size_of = 4'h3;
         4'h4: size_of = 4'h4;
         4'h3: size_of = 4'h5;
         4'h1: size_of = 4'h6;
         4'h0: size_of = 4'h7;
         4'h5: size_of = 4'h8;
         default: size_of = 4'h0;
      endcase
   endfunction

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // =====
   // properties
   a_code_low_zero: assert property (display_code_out[3:0] == 4'h0)
      else $error("display code low nibble not zero");
   a_valid_size_map: assert property (
      size_valid_out && !full_area_scan_out
      |-> size_out == size_of(display_code_out[7:4]))
      else $error("size does not match accepted pattern");
   a_undet_invalid: assert property (
      undetectable_out |-> !size_valid_out
      && size_of(display_code_out[7:4]) == 4'h0)
      else $error("undetectable flag on accepted pattern");
   a_full_area_xl: assert property (
      full_area_scan_out |-> {size_out, display_code_out, undetectable_out,
      size_valid_out} == {4'h1, 8'hf0, 2'b01})
      else $error("by-pass result is not full area");
   // results move only after a cover rise or a start press
   a_eval_instant: assert property (
      $changed(res) |-> $past(start_key_in)
      || ($past(platen_cover_in, 3) && !$past(platen_cover_in, 4)))
      else $error("results changed outside an evaluation");
   a_code_from_pins: assert property (
      $changed(res) && !full_area_scan_out
      |-> display_code_out[7:4] == $past(pin_pat, 3))
      else $error("code differs from the sensor pins");
   a_wait_one_cycle: assert property (
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");
   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus request not answered next cycle");
   a_video_gate: assert property (video_out |-> $past(video_in))
      else $error("video out without video in");

   // main scenarios seen
   c_undet: cover property ($rose(undetectable_out));
   c_full: cover property ($rose(full_area_scan_out));
   c_cut: cover property ($fell(video_out) && $past(video_in));
endmodule

bind osd_detector osd_detector_properties chk (.clk_in, .sys_rst_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .width_sense_first_in,
   .width_sense_second_in, .length_sense_first_in, .length_sense_second_in,
   .platen_cover_in, .start_key_in, .video_in, .size_out, .display_code_out,
   .undetectable_out, .size_valid_out, .full_area_scan_out, .video_out);

// ==== verification/osd_sensor_model.sv ====
// model of the reflective size photosensors and the platen cover sensor
`timescale 1ns/1ps
module osd_sensor_model (
   // paper seen as {l2, l1, w2, w1}, cover position
   input wire logic [3:0] paper_in,
   input wire logic cover_closing_in,
   // sensor pins, low level means paper on the four size pins; the cover pin is high while closing
   output logic width_sense_first_out,
   output logic width_sense_second_out,
   output logic length_sense_first_out,
   output logic length_sense_second_out,
   output logic platen_cover_out
);
   // sensors are live all the time; paper pulls a pin low
   assign {length_sense_second_out, length_sense_first_out,
      width_sense_second_out, width_sense_first_out} = ~paper_in;
   assign platen_cover_out = cover_closing_in;
endmodule

// ==== verification/test_original_size_detector.sv ====
// self-checking testbench for the original size detector
`timescale 1ns/1ps
module test_original_size_detector;
   // =====
   // stimulus and observed signals
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [4:0] avs_address_in = 5'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic width_sense_first_in, width_sense_second_in;
   logic length_sense_first_in, length_sense_second_in, platen_cover_in;
   logic reg_sensor_in = 1'b0;
   logic start_key_in = 1'b0;
   logic page_start_in = 1'b0;
   logic line_tick_in = 1'b0;
   logic video_in = 1'b0;
   logic [3:0] paper = 4'h0;
   logic cover_closing = 1'b0;
   osd_pkg::osd_size_t size_out;
   logic [7:0] display_code_out;
   logic undetectable_out, size_valid_out, full_area_scan_out;
   logic video_out, irq_out;
   logic [14:0] exp_prev = 15'h0;
   logic [31:0] rd;
   int n_errors = 0;
   int n_compared = 0;

   always #2.5 clk_in = ~clk_in;

   osd_detector uut (.clk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_waitrequest_out, .width_sense_first_in, .width_sense_second_in,
      .length_sense_first_in, .length_sense_second_in, .platen_cover_in,
      .reg_sensor_in, .start_key_in, .page_start_in, .line_tick_in, .video_in,
      .size_out, .display_code_out, .undetectable_out, .size_valid_out,
      .full_area_scan_out, .video_out, .irq_out);

   osd_sensor_model sensors (.paper_in(paper), .cover_closing_in(cover_closing),
      .width_sense_first_out(width_sense_first_in),
      .width_sense_second_out(width_sense_second_in),
      .length_sense_first_out(length_sense_first_in),
      .length_sense_second_out(length_sense_second_in),
      .platen_cover_out(platen_cover_in));

   // =====
   // helpers; every task but chk and end_sim returns just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // outputs are read 1 ns after the edge so its updates have landed
   task automatic res(input logic [14:0] e);
      #1;
      chk({17'h0, size_out, display_code_out, undetectable_out,
         size_valid_out, full_area_scan_out}, {17'h0, e});
      @(posedge clk_in);
   endtask

   task automatic flags(input logic ev, input logic ei);
      #1;
      chk({30'h0, video_out, irq_out}, {30'h0, ev, ei});
      @(posedge clk_in);
   endtask

   function automatic logic [14:0] ex(input logic [3:0] s, input logic [3:0] p,
         input logic [2:0] uvf);
      ex = {s, p, 4'h0, uvf};
   endfunction

   // one access; the request holds until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int i;
      i = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge clk_in);
         i++;
      end while (avs_waitrequest_out !== 1'b0 && i < 40);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (avs_waitrequest_out !== 1'b0) begin
         n_errors++;
         end_sim();
      end
      @(posedge clk_in);
   endtask

   task automatic lines(input int n);
      repeat (n) begin
         line_tick_in <= 1'b1;
         tick(1);
         line_tick_in <= 1'b0;
         tick(1);
      end
   endtask

   // paper moves with the cover open and again while it is closed
   task automatic close_on(input logic [3:0] p, input logic [14:0] e);
      paper <= p;
      tick(4);
      res(exp_prev);
      cover_closing <= 1'b1;
      tick(6);
      res(e);
      // sensors move and start is pressed, both with the cover down
      paper <= ~p;
      start_key_in <= 1'b1;
      tick(1);
      start_key_in <= 1'b0;
      tick(3);
      res(e);
      exp_prev = e;
      cover_closing <= 1'b0;
      tick(4);
   endtask

   // =====
   // scenarios
   task automatic t_regs;
      avs_byteenable_in <= 4'he;
      bus(1'b1, 5'h00, 32'h3);
      avs_byteenable_in <= 4'hf;
      bus(1'b1, 5'h04, 32'hffffffff);
      bus(1'b1, 5'h14, 32'hffffffff);
      for (int a = 0; a < 24; a += 4) begin
         bus(1'b0, 5'(a), 32'h0);
         chk(rd, 32'h0);
      end
   endtask

   task automatic t_patterns;
      logic [3:0] pats [8] = '{4'hf, 4'hd, 4'hc, 4'h4, 4'h3, 4'h1, 4'h0, 4'h5};
      for (int i = 0; i < 8; i++) begin
         close_on(pats[i], ex(4'(i + 1), pats[i], 3'b010));
         bus(1'b0, 5'h04, 32'h0);
         chk(rd, {12'h0, ~pats[i], 4'h2, 4'(i + 1), pats[i], 4'h0});
      end
   endtask

   // pending evaluation bit is masked, then unmasked, then cleared
   task automatic t_irq;
      flags(1'b0, 1'b0);
      bus(1'b0, 5'h08, 32'h0);
      chk(rd, 32'h1);
      bus(1'b1, 5'h0c, 32'h1);
      tick(1);
      flags(1'b0, 1'b1);
      bus(1'b1, 5'h08, 32'h1);
      tick(1);
      flags(1'b0, 1'b0);
      bus(1'b0, 5'h08, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_undet;
      close_on(4'h2, ex(4'h0, 4'h2, 3'b100));
      bus(1'b1, 5'h00, 32'h2);
      close_on(4'h6, ex(4'h0, 4'h6, 3'b000));
      bus(1'b1, 5'h00, 32'h0);
   endtask

   task automatic t_start;
      paper <= 4'hc;
      tick(4);
      start_key_in <= 1'b1;
      tick(1);
      start_key_in <= 1'b0;
      exp_prev = ex(4'h3, 4'hc, 3'b010);
      res(exp_prev);
   endtask

   // full area result, then measured length cuts the video
   task automatic t_bypass;
      bus(1'b1, 5'h08, 32'h7);
      bus(1'b1, 5'h0c, 32'h4);
      bus(1'b1, 5'h00, 32'h1);
      close_on(4'h2, ex(4'h1, 4'hf, 3'b011));
      reg_sensor_in <= 1'b1;
      tick(3);
      lines(5);
      reg_sensor_in <= 1'b0;
      tick(4);
      bus(1'b0, 5'h10, 32'h0);
      chk(rd, 32'h5);
      // lines run free before any page, so a cut may already be pending
      bus(1'b1, 5'h08, 32'h4);
      page_start_in <= 1'b1;
      video_in <= 1'b1;
      tick(1);
      page_start_in <= 1'b0;
      lines(4);
      flags(1'b1, 1'b0);
      lines(1);
      tick(2);
      flags(1'b0, 1'b1);
      video_in <= 1'b0;
      bus(1'b1, 5'h00, 32'h0);
   endtask

   task automatic end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      tick(10);
      sys_rst_in <= 1'b0;
      tick(1);
      t_regs();
      t_patterns();
      t_irq();
      t_undet();
      t_start();
      t_bypass();
      end_sim();
   end
endmodule
